// >>> src/sac_defs.vh
// Purpose: constants for the sar conversion control block
// Assumes: 50 MHz system clock, converter clock derived by enable
// Notes: header only, definitions
`ifndef SAC_DEFS_VH
`define SAC_DEFS_VH
// ----------------------------------------
// widths and sequencing
// ----------------------------------------
`define SAC_NBITS 8
`define SAC_SLOT_CYC 8
`define SAC_CONV_CYC 64
`define SAC_FULL_SCALE 8'hff
// converter clock enable divider (50 MHz / 78 ~ 640 kHz)
`define SAC_DIV_CNT 7'h4e
`define SAC_DIV_W 7
// start sync: converter ticks before conversion may begin, max 8
`define SAC_PHASE_MAX 3'h7
// last tick of an eight tick bit slot
`define SAC_SLOT_LAST 3'h7
// token pattern entering the first shift stage
`define SAC_TOKEN_ENTRY 8'h01
// slot count at whose half tick the negative input is sampled (4.5 periods later)
`define SAC_NEG_TICK 3'h5
`endif

// >>> src/sac_tick_div.v
// Purpose: one-cycle converter clock enable from the system clock
// Assumes: single clock domain
// Notes: period set by SAC_DIV_CNT
`timescale 1ns/1ps
`include "sac_defs.vh"
module sac_tick_div (
  input wire clk_sys,
  input wire nrst,
  output wire tick,
  output wire half_tick
);
  reg [`SAC_DIV_W-1:0] cnt_q;
  // ----------------------------------------
  // divider
  // ----------------------------------------
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= {`SAC_DIV_W{1'b0}};
    end else if (cnt_q == `SAC_DIV_CNT - 7'h01) begin
      cnt_q <= {`SAC_DIV_W{1'b0}};
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end
  assign tick = (cnt_q == `SAC_DIV_CNT - 7'h01);
  assign half_tick = (cnt_q == (`SAC_DIV_CNT >> 1) - 7'h01);
endmodule

// >>> src/sac_sync2.v
// Purpose: two-flop synchroniser for pin inputs
// Assumes: async input
// Notes: first stage read only by second
`timescale 1ns/1ps
module sac_sync2 #(
  parameter W = 4,
  parameter RST = 4'hf
) (
  input wire clk_sys,
  input wire nrst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_q <= RST;
      q <= RST;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// >>> src/sac_conv_ctrl.v
// Purpose: control of an 8-bit successive approximation converter
// Assumes: analog comparator result arrives as a pin input; one clock
// Notes: nrst is the internal power-on reset only; start strobe resets sequencing and done, not the output latch
`timescale 1ns/1ps
`include "sac_defs.vh"
module sac_conv_ctrl (
  input wire clk_sys,
  input wire nrst,
  input wire sel_n,
  input wire start_n,
  input wire read_n,
  input wire cmp_above,
  output reg [7:0] data_out,
  output reg [7:0] data_oe,
  output wire done_flag_n,
  output reg [7:0] trial_code,
  output reg sample_pos,
  output reg sample_neg,
  output wire busy
);
  wire tick;
  wire half_tick;
  wire [3:0] pins_s;
  wire sel_s;
  wire start_s;
  wire read_s;
  wire cmp_s;
  reg start_ff_q;
  reg token_entry_stage_q;
  reg [7:0] shift_q;
  reg token_exit_stage_q;
  reg done_q;
  reg [7:0] sar_q;
  reg [7:0] latch_q;
  reg [2:0] slot_q;
  reg [2:0] phase_q;
  reg start_ff_d;
  reg token_entry_stage_d;
  reg [2:0] phase_d;
  reg [7:0] shift_d;
  reg [2:0] slot_d;
  reg [7:0] sar_d;
  reg token_exit_stage_d;
  reg [7:0] latch_d;
  reg done_d;
  wire read_req;
  wire set_cond;
  wire start_clear_gate;
  wire latch_transfer_gate;
  wire [2:0] bit_idx;

  // ----------------------------------------
  // input synchronisers and clock enable
  // ----------------------------------------
  sac_sync2 #(.W(4), .RST(4'he)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d({sel_n, start_n, read_n, cmp_above}),
    .q(pins_s)
  );
  assign sel_s = pins_s[3];
  assign start_s = pins_s[2];
  assign read_s = pins_s[1];
  assign cmp_s = pins_s[0];

  sac_tick_div u_div (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .tick(tick),
    .half_tick(half_tick)
  );

  // bit under trial from the token position, msb first
  function [2:0] f_bit_idx;
    input [7:0] sh;
    integer i;
    begin
      f_bit_idx = 3'h7;
      for (i = 0; i < 8; i = i + 1) begin
        if (sh[i]) begin
          f_bit_idx = 3'h7 - i[2:0];
        end
      end
    end
  endfunction
  assign bit_idx = f_bit_idx(shift_q);

  // one-hot mask for a bit position
  function [7:0] f_bit_mask;
    input [2:0] idx;
    begin
      f_bit_mask = 8'h01 << idx;
    end
  endfunction

  // approximation word with one bit replaced by the decision
  function [7:0] f_keep_bit;
    input [7:0] word;
    input [2:0] idx;
    input keep;
    begin
      f_keep_bit = keep ? (word | f_bit_mask(idx)) : (word & ~f_bit_mask(idx));
    end
  endfunction

  // ----------------------------------------
  // start flop
  // ----------------------------------------
  // both low: set condition
  assign set_cond = !sel_s && !start_s;
  assign start_clear_gate = token_entry_stage_q && tick && (phase_q == `SAC_PHASE_MAX) && !set_cond;
  always @* begin
    start_ff_d = start_ff_q;
    // set by select and start low
    if (set_cond) begin
      start_ff_d = 1'b1;
    end else if (start_clear_gate) begin
      start_ff_d = 1'b0;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      start_ff_q <= 1'b0;
    end else begin
      start_ff_q <= start_ff_d;
    end
  end

  // ----------------------------------------
  // entry stage and start phase alignment
  // ----------------------------------------
  // eight tick alignment before token enters
  always @* begin
    token_entry_stage_d = token_entry_stage_q;
    phase_d = phase_q;
    if (set_cond) begin
      token_entry_stage_d = 1'b1;
      phase_d = 3'h0;
    end else if (start_clear_gate) begin
      token_entry_stage_d = 1'b0;
      phase_d = 3'h0;
    end else if (token_entry_stage_q && tick) begin
      phase_d = phase_q + 3'h1;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      token_entry_stage_q <= 1'b0;
      phase_q <= 3'h0;
    end else begin
      token_entry_stage_q <= token_entry_stage_d;
      phase_q <= phase_d;
    end
  end

  // ----------------------------------------
  // sequencing shift register and sar
  // ----------------------------------------
  assign busy = |shift_q;
  assign latch_transfer_gate = shift_q[7] && tick && (slot_q == `SAC_SLOT_LAST);
  always @* begin
    shift_d = shift_q;
    slot_d = slot_q;
    sar_d = sar_q;
    token_exit_stage_d = token_exit_stage_q;
    if (start_clear_gate) begin
      shift_d = `SAC_TOKEN_ENTRY;
      slot_d = 3'h0;
      sar_d = 8'h00;
      token_exit_stage_d = 1'b0;
    end else if (start_ff_q) begin
      shift_d = 8'h00;
      slot_d = 3'h0;
      sar_d = 8'h00;
      token_exit_stage_d = 1'b0;
    end else if (tick) begin
      if (busy) begin
        slot_d = slot_q + 3'h1;
        if (slot_q == `SAC_SLOT_LAST) begin
          // keep bit when input above trial
          sar_d = f_keep_bit(sar_q, bit_idx, cmp_s);
          shift_d = {shift_q[6:0], 1'b0};
        end
      end
      // exit stage clocked after token leaves
      token_exit_stage_d = latch_transfer_gate;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shift_q <= 8'h00;
      slot_q <= 3'h0;
      sar_q <= 8'h00;
      token_exit_stage_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      slot_q <= slot_d;
      sar_q <= sar_d;
      token_exit_stage_q <= token_exit_stage_d;
    end
  end

  // trial value with current bit set
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      trial_code <= 8'h00;
    end else if (busy) begin
      trial_code <= sar_q | f_bit_mask(bit_idx);
    end else begin
      trial_code <= sar_q;
    end
  end

  // sample strobes 4.5 ticks apart in each slot
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sample_pos <= 1'b0;
      sample_neg <= 1'b0;
    end else begin
      sample_pos <= busy && tick && (slot_q == 3'h0);
      sample_neg <= busy && half_tick && (slot_q == `SAC_NEG_TICK);
    end
  end

  // ----------------------------------------
  // output latch and done flop
  // ----------------------------------------
  // select and read low together
  assign read_req = !sel_s && !read_s;
  always @* begin
    latch_d = latch_q;
    if (latch_transfer_gate && !start_ff_q) begin
      latch_d = f_keep_bit(sar_q, 3'h0, cmp_s);
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      latch_q <= 8'h00;
    end else begin
      latch_q <= latch_d;
    end
  end

  always @* begin
    done_d = done_q;
    if (start_ff_q) begin
      done_d = 1'b0;
    end else if (token_exit_stage_q && tick) begin
      done_d = 1'b1;
    end else if (read_req) begin
      done_d = 1'b0;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  assign done_flag_n = !done_q;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      data_out <= 8'h00;
      data_oe <= 8'h00;
    end else begin
      data_out <= latch_q;
      data_oe <= {8{read_req}};
    end
  end
endmodule

// >>> bench/sac_cmp_model.sv
// Purpose: comparator model at the analog side
// Assumes: input held steady during a conversion
// Notes: half lsb offset folded into the compare
`timescale 1ns/1ps
module sac_cmp_model (
  input wire [7:0] vin,
  input wire [7:0] trial_code,
  output wire cmp_above
);
  assign cmp_above = ({vin, 1'b1} > {trial_code, 1'b0});
endmodule

// >>> bench/sac_conv_ctrl_props.sv
// Purpose: port checker for sac_conv_ctrl
// Assumes: one clock, nrst async low
// Notes: bound to every instance
`timescale 1ns/1ps
module sac_conv_ctrl_props (
  input wire clk_sys,
  input wire nrst,
  input wire sel_n,
  input wire start_n,
  input wire read_n,
  input wire [7:0] data_out,
  input wire [7:0] data_oe,
  input wire done_flag_n,
  input wire [7:0] trial_code,
  input wire sample_pos,
  input wire sample_neg,
  input wire busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_start;
    (!sel_n && !start_n) [*4];
  endsequence
  sequence s_read;
    (!sel_n && !read_n) [*4];
  endsequence
  a_start_holds_reset: assert property (s_start |=> !busy && done_flag_n)
    else $error("busy while start held");
  a_read_drives_data: assert property (s_read |=> data_oe == 8'hff && done_flag_n)
    else $error("read did not drive or clear");
  a_idle_high_z: assert property ((sel_n || read_n) [*4] |=> data_oe == 8'h00)
    else $error("outputs driven without read");
  a_oe_whole_word: assert property (data_oe == 8'h00 || data_oe == 8'hff)
    else $error("partial output enable");
  a_busy_done_high: assert property (busy |-> done_flag_n)
    else $error("done low during conversion");
  a_msb_trial_first: assert property ($rose(busy) |-> ##[0:80] trial_code == 8'h80)
    else $error("msb not tried first");
  a_latch_then_done: assert property ($changed(data_out) |-> ##[1:80] $fell(done_flag_n))
    else $error("done late after latch");
  a_pos_one_cycle: assert property (sample_pos |=> !sample_pos)
    else $error("sample pulse too long");
  a_neg_after_pos: assert property (disable iff (!nrst || (!sel_n && !start_n)) sample_pos |-> ##[345:357] sample_neg)
    else $error("negative sample misplaced");
endmodule
bind sac_conv_ctrl sac_conv_ctrl_props u_props (.clk_sys(clk_sys), .nrst(nrst), .sel_n(sel_n),
  .start_n(start_n), .read_n(read_n), .data_out(data_out), .data_oe(data_oe), .done_flag_n(done_flag_n),
  .trial_code(trial_code), .sample_pos(sample_pos), .sample_neg(sample_neg), .busy(busy));

// >>> bench/sac_conv_ctrl_tb.sv
// Purpose: self-checking bench for sac_conv_ctrl
// Assumes: 50 MHz clk_sys, inputs set on falling edge
// Notes: comparator model answers the trial code
`timescale 1ns/1ps
module sac_conv_ctrl_tb;
  reg clk_sys = 1'b0;
  reg nrst = 1'b0;
  reg sel_n = 1'b1;
  reg st_n = 1'b1;
  reg read_n = 1'b1;
  reg free_run = 1'b0;
  reg [7:0] vin = 8'h00;
  wire start_n;
  wire cmp_above;
  wire [7:0] data_out;
  wire [7:0] data_oe;
  wire [7:0] trial_code;
  wire done_flag_n;
  wire busy;
  integer bad_count = 0;
  integer checks = 0;
  integer cyc = 0;
  integer n;
  assign start_n = st_n & (free_run ? done_flag_n : 1'b1);
  always #10 clk_sys = ~clk_sys;
  sac_cmp_model u_cmp (.vin(vin), .trial_code(trial_code), .cmp_above(cmp_above));
  sac_conv_ctrl dut (.clk_sys(clk_sys), .nrst(nrst), .sel_n(sel_n), .start_n(start_n), .read_n(read_n),
    .cmp_above(cmp_above), .data_out(data_out), .data_oe(data_oe), .done_flag_n(done_flag_n),
    .trial_code(trial_code), .sample_pos(), .sample_neg(), .busy(busy));
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task go(input [7:0] v);
    begin
      @(negedge clk_sys);
      vin = v;
      sel_n = 1'b0;
      st_n = 1'b0;
      repeat (4) @(negedge clk_sys);
      sel_n = 1'b1;
      st_n = 1'b1;
    end
  endtask
  task wait_done(input lvl);
    begin
      n = 0;
      while (done_flag_n !== lvl && n < 6000) begin
        @(negedge clk_sys);
        n = n + 1;
      end
    end
  endtask
  task rd(input [7:0] v);
    begin
      @(negedge clk_sys);
      sel_n = 1'b0;
      read_n = 1'b0;
      repeat (4) @(negedge clk_sys);
      chk(data_oe, 8'hff);
      chk(data_out, v);
      chk({7'h0, done_flag_n}, 8'h01);
      sel_n = 1'b1;
      read_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk(data_oe, 8'h00);
    end
  endtask
  task t_conv(input [7:0] v);
    begin
      go(v);
      wait_done(1'b0);
      chk({7'h0, n >= 4836 && n <= 5700}, 8'h01);
      rd(v);
    end
  endtask
  task t_hold;
    begin
      @(negedge clk_sys);
      vin = 8'h3c;
      sel_n = 1'b0;
      st_n = 1'b0;
      repeat (700) @(negedge clk_sys);
      chk({6'h0, busy, done_flag_n}, 8'h01);
      sel_n = 1'b1;
      n = 0;
      while (busy !== 1'b1 && n < 700) begin
        @(negedge clk_sys);
        n = n + 1;
      end
      chk({7'h0, n <= 628}, 8'h01);
      st_n = 1'b1;
      wait_done(1'b0);
      rd(8'h3c);
    end
  endtask
  task t_restart;
    begin
      go(8'h96);
      repeat (2000) @(negedge clk_sys);
      go(8'h5a);
      repeat (1000) @(negedge clk_sys);
      rd(8'h3c);
      wait_done(1'b0);
      rd(8'h5a);
    end
  endtask
  task t_free;
    begin
      go(8'h77);
      @(negedge clk_sys);
      sel_n = 1'b0;
      free_run = 1'b1;
      wait_done(1'b0);
      wait_done(1'b1);
      chk({7'h0, n < 20}, 8'h01);
      wait_done(1'b0);
      chk({7'h0, n >= 4800 && n <= 5700}, 8'h01);
      wait_done(1'b1);
      free_run = 1'b0;
      rd(8'h77);
    end
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    nrst = 1'b1;
    chk({6'h0, busy, done_flag_n}, 8'h01);
    t_conv(8'hff);
    t_conv(8'h00);
    t_conv(8'ha5);
    t_hold;
    t_restart;
    t_free;
    test_done;
  end
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 90000) begin
      bad_count = bad_count + 1;
      test_done;
    end
  end
endmodule
